// [logic/pbs_sram_core.sv]
// pipelined burst sram: access pipeline, burst counter, byte lane core
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_core
  import pbs_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF
)
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clockQualifyN, // high ignores the clock edge
  input wire logic [ADDR_W-1:0] address, // word address
  input wire logic bankSelect1N, // bank select, active low
  input wire logic bankSelect2, // bank select, active high
  input wire logic bankSelect3N, // bank select, active low
  input wire logic advanceOrLoad, // high advances, low loads
  input wire logic writeStrobeN, // low selects write on load
  input wire logic [LANES-1:0] byteLaneSelectN, // lane writes, low
  input wire logic outputDriveN, // asynchronous drive enable, low
  input wire logic burstOrder, // strap: high interleaved
  input wire logic sleepRequest, // asynchronous sleep, high
  input wire logic [LANES*BYTE_W-1:0] dataIn, // data bus in
  output logic [LANES*BYTE_W-1:0] dataOut, // data bus out
  output logic dataOe, // data bus driven
  input wire logic [LANES-1:0] parityIn, // parity lanes in
  output logic [LANES-1:0] parityOut, // parity lanes out
  output logic parityOe, // parity lanes driven
  input wire logic tck, // test clock pin
  input wire logic tms, // test mode select pin
  output pbs_tap_state_t tapState, // test port state
  output logic sleeping // sleep state reached
);

  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem_r [DEPTH];
  logic [1:0] strapSync1_r;
  logic [1:0] strapSync2_r;
  logic [1:0] strapSync3_r;
  logic [1:0] strapLevel_r;
  logic sleepLevel;
  logic orderLevel;
  logic allSelect;
  logic stepOk;
  logic qualOk;
  logic activeA_r;
  logic writeA_r;
  logic [ADDR_W-1:0] addrA_r;
  logic [LANES-1:0] laneA_r;
  logic [BURST_POS_W-1:0] startLow_r;
  logic [BURST_POS_W-1:0] cnt_r;
  logic [BURST_POS_W-1:0] cnt_nxt;
  logic validB_r;
  logic [ADDR_W-1:0] addrB_r;
  logic [LANES-1:0] laneB_r;
  logic [WORD_W-1:0] readWord;
  logic [WORD_W-1:0] writeWord;
  logic bufInReady;
  logic bufOutValid;
  logic [WORD_W:0] bufHead;
  logic headDrive;
  logic driveOn;

  function automatic logic [BURST_POS_W-1:0] burstLow(
    input logic [BURST_POS_W-1:0] start,
    input logic [BURST_POS_W-1:0] pos,
    input logic interleave
  );
    burstLow = interleave ? (start ^ pos) : (start + pos);
  endfunction : burstLow

  // ----------------------------------------------------------------
  // asynchronous pins: sleep and burst order strap
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strapSync1_r <= STRAP_SYNC_RST;
      strapSync2_r <= STRAP_SYNC_RST;
      strapSync3_r <= STRAP_SYNC_RST;
      strapLevel_r <= STRAP_SYNC_RST;
    end
    else
    begin
      strapSync1_r <= {burstOrder, sleepRequest};
      strapSync2_r <= strapSync1_r;
      strapSync3_r <= strapSync2_r;
      for (int i = 0; i < 2; i++)
      begin
        if (strapSync2_r[i] == strapSync3_r[i])
        begin
          strapLevel_r[i] <= strapSync3_r[i];
        end
      end
    end
  end

  assign sleepLevel = strapLevel_r[0];
  assign orderLevel = strapLevel_r[1];
  assign sleeping = sleepLevel;

  // ----------------------------------------------------------------
  // clock qualification
  // ----------------------------------------------------------------
  // sleep freezes the pipeline too, so no stray write can disturb
  // the array while the core is at low power
  assign stepOk = !clockQualifyN && !sleepLevel;
  assign qualOk = stepOk && bufInReady;
  assign allSelect = !bankSelect1N && bankSelect2 && !bankSelect3N;
  assign cnt_nxt = cnt_r + 2'h1;

  // ----------------------------------------------------------------
  // stage A: address register and burst counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      activeA_r <= 1'b0;
      writeA_r <= 1'b0;
      addrA_r <= '0;
      laneA_r <= '1;
      startLow_r <= BURST_CNT_RST;
      cnt_r <= BURST_CNT_RST;
    end
    else if (qualOk)
    begin
      laneA_r <= byteLaneSelectN;
      if (!advanceOrLoad)
      begin
        activeA_r <= allSelect;
        if (allSelect)
        begin
          addrA_r <= address;
          writeA_r <= !writeStrobeN;
          startLow_r <= address[1:0];
          cnt_r <= BURST_CNT_RST;
        end
      end
      else
      begin
        // selects and write strobe are not looked at here
        cnt_r <= cnt_nxt;
        addrA_r[1:0] <= burstLow(startLow_r, cnt_nxt, orderLevel);
      end
    end
  end

  // ----------------------------------------------------------------
  // stage B: write waits one edge for its data
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      validB_r <= 1'b0;
      addrB_r <= '0;
      laneB_r <= '1;
    end
    else if (qualOk)
    begin
      validB_r <= activeA_r && writeA_r;
      addrB_r <= addrA_r;
      laneB_r <= laneA_r;
    end
  end

  // ----------------------------------------------------------------
  // memory array, written lane by lane
  // ----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    assign writeWord[l*LANE_W +: LANE_W] =
      {parityIn[l], dataIn[l*BYTE_W +: BYTE_W]};
    assign dataOut[l*BYTE_W +: BYTE_W] = bufHead[l*LANE_W +: BYTE_W];
    assign parityOut[l] = bufHead[l*LANE_W + BYTE_W];
  end

  // one process owns the array; lanes are masked inside it
  always_ff @(posedge clk)
  begin
    if (qualOk && validB_r)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (!laneB_r[l])
        begin
          mem_r[addrB_r][l*LANE_W +: LANE_W] <=
            writeWord[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign readWord = mem_r[addrA_r];

  // ----------------------------------------------------------------
  // output register: two-entry buffer, head drives the pins
  // ----------------------------------------------------------------
  // every qualified edge pushes one word and pops the old head, so
  // the head is always the output of the last edge; a stall does
  // neither and the head stays put
  pbs_skid_buffer #(
    .WIDTH(WORD_W + 1),
    .DEPTH(BUF_DEPTH_DEF)
  ) u_out_buf (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(stepOk),
    .inReady(bufInReady),
    .inData({activeA_r && !writeA_r, readWord}),
    .outValid(bufOutValid),
    .outReady(stepOk),
    .outData(bufHead)
  );

  assign headDrive = bufOutValid && bufHead[WORD_W];
  // the drive enable pin is asynchronous and only gates the drivers
  assign driveOn = headDrive && !outputDriveN && !sleepLevel;
  assign dataOe = driveOn;
  assign parityOe = driveOn;

  // ----------------------------------------------------------------
  // test access port
  // ----------------------------------------------------------------
  pbs_tap_ctrl u_tap (
    .clk(clk),
    .rst_n(rst_n),
    .tck(tck),
    .tms(tms),
    .tapState(tapState)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [LANE_W-1:0] lane0Old;
  logic [BURST_POS_W-1:0] expectLow;
  assign lane0Old = mem_r[addrB_r][LANE_W-1:0];
  assign expectLow = burstLow(startLow_r, cnt_nxt, orderLevel);

  sequence s_read_load;
    qualOk && !advanceOrLoad && allSelect && writeStrobeN;
  endsequence
  sequence s_write_load;
    qualOk && !advanceOrLoad && allSelect && !writeStrobeN;
  endsequence
  sequence s_deselect;
    qualOk && !advanceOrLoad && !allSelect;
  endsequence

  a_load_address : assert property (@(posedge clk) disable iff (!rst_n)
    qualOk && !advanceOrLoad && allSelect |=> addrA_r == $past(address))
    else $error("selected load did not take the address");
  a_read_latency : assert property (@(posedge clk) disable iff (!rst_n)
    s_read_load ##1 qualOk |=> headDrive
    && bufHead[WORD_W-1:0] == $past(readWord))
    else $error("read data not driven one edge after load");
  a_read_back2back : assert property (@(posedge clk) disable iff (!rst_n)
    s_read_load ##1 (qualOk && !advanceOrLoad && allSelect)
    |=> addrA_r == $past(address))
    else $error("operation after read start was not accepted");
  a_write_tristate : assert property (@(posedge clk) disable iff (!rst_n)
    s_write_load ##1 qualOk |=> !dataOe && !parityOe)
    else $error("outputs driven in write data cycle");
  a_deselect_pipe : assert property (@(posedge clk) disable iff (!rst_n)
    s_deselect ##1 qualOk |=> !dataOe)
    else $error("outputs driven after deselect");
  a_drive_needs_oe : assert property (@(posedge clk) disable iff (!rst_n)
    dataOe |-> !outputDriveN && headDrive)
    else $error("data driven without enable");
  a_stall_holds : assert property (@(posedge clk) disable iff (!rst_n)
    !stepOk |=> $stable(bufHead) && $stable(headDrive) && $stable(addrA_r)
    && $stable(cnt_r))
    else $error("state moved on an ignored edge");
  a_burst_order : assert property (@(posedge clk) disable iff (!rst_n)
    qualOk && advanceOrLoad |=> addrA_r[1:0] == $past(expectLow)
    && addrA_r[ADDR_W-1:2] == $past(addrA_r[ADDR_W-1:2]))
    else $error("burst address step wrong");
  a_burst_type : assert property (@(posedge clk) disable iff (!rst_n)
    qualOk && advanceOrLoad |=> $stable(writeA_r) && $stable(activeA_r))
    else $error("burst beat changed access type or select");
  a_lane_write : assert property (@(posedge clk) disable iff (!rst_n)
    qualOk && validB_r |=> mem_r[$past(addrB_r)][LANE_W-1:0] ==
    ($past(laneB_r[0]) ? $past(lane0Old) : $past(writeWord[LANE_W-1:0])))
    else $error("byte lane zero written wrongly");
  a_sleep_quiet : assert property (@(posedge clk) disable iff (!rst_n)
    sleepLevel |-> !dataOe ##1 $stable(bufHead))
    else $error("activity during sleep");
  a_reset_quiet : assert property (@(posedge clk)
    !rst_n |=> !dataOe && !activeA_r && !validB_r)
    else $error("not deselected after reset");

endmodule : pbs_sram_core
`default_nettype wire

// [shared/pbs_pkg.sv]
// shared constants and types of the pipelined burst sram access block
package pbs_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF = 21;
  localparam int LANES_DEF = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int BURST_POS_W = 2;
  localparam int BUF_DEPTH_DEF = 2;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic SLEEP_RST = 1'b0;
  // an open strap pin floats high, so interleaved is the safe default
  localparam logic ORDER_RST = 1'b1;
  localparam logic [1:0] STRAP_SYNC_RST = {ORDER_RST, SLEEP_RST};

  // ----------------------------------------------------------------
  // test access port states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET = 4'hf,
    TAP_IDLE = 4'hc,
    TAP_SEL_DR = 4'h7,
    TAP_CAP_DR = 4'h6,
    TAP_SHIFT_DR = 4'h2,
    TAP_EXIT1_DR = 4'h1,
    TAP_PAUSE_DR = 4'h3,
    TAP_EXIT2_DR = 4'h0,
    TAP_UPD_DR = 4'h5,
    TAP_SEL_IR = 4'h4,
    TAP_CAP_IR = 4'he,
    TAP_SHIFT_IR = 4'ha,
    TAP_EXIT1_IR = 4'h9,
    TAP_PAUSE_IR = 4'hb,
    TAP_EXIT2_IR = 4'h8,
    TAP_UPD_IR = 4'hd
  } pbs_tap_state_t;

endpackage : pbs_pkg

// [logic/pbs_skid_buffer.sv]
// two-entry flop buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pbs_skid_buffer
  import pbs_pkg::*;
#(
  parameter int WIDTH = 37,
  parameter int DEPTH = BUF_DEPTH_DEF
)
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic inValid, // word offered
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word in
  output logic outValid, // head word present
  input wire logic outReady, // head word taken
  output logic [WIDTH-1:0] outData // head word, from flops
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] entry_r [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0] count_r;
  logic push;
  logic pop;

  assign inReady = (count_r != (PTR_W+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = entry_r[rdPtr_r];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      entry_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_r <= (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop)
      begin
        rdPtr_r <= (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  a_buffer_bound : assert property (@(posedge clk) disable iff (!rst_n)
    count_r <= (PTR_W+1)'(DEPTH))
    else $error("buffer holds more words than its depth");

endmodule : pbs_skid_buffer
`default_nettype wire

// [logic/pbs_tap_ctrl.sv]
// test access port state machine stepped by a sampled test clock
`timescale 1ns/1ps
`default_nettype none
module pbs_tap_ctrl
  import pbs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic tck, // test clock pin
  input wire logic tms, // test mode select pin
  output pbs_tap_state_t tapState // current port state
);

  logic [SYNC_STAGES-1:0] tckSync_r;
  logic [SYNC_STAGES-1:0] tmsSync_r;
  logic tckLevel_r;
  logic tmsLevel_r;
  logic tckRise;
  pbs_tap_state_t state_r;
  pbs_tap_state_t state_nxt;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tckSync_r <= '0;
      tmsSync_r <= '1;
      tckLevel_r <= 1'b0;
      tmsLevel_r <= 1'b1;
    end
    else
    begin
      tckSync_r <= {tckSync_r[SYNC_STAGES-2:0], tck};
      tmsSync_r <= {tmsSync_r[SYNC_STAGES-2:0], tms};
      if (tckSync_r[1] == tckSync_r[2])
      begin
        tckLevel_r <= tckSync_r[2];
      end
      if (tmsSync_r[1] == tmsSync_r[2])
      begin
        tmsLevel_r <= tmsSync_r[2];
      end
    end
  end

  // tms runs through the same depth as tck, so both stay aligned
  assign tckRise = (tckSync_r[1] == tckSync_r[2]) && tckSync_r[2]
    && !tckLevel_r;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TAP_RESET: state_nxt = tmsLevel_r ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_nxt = tmsLevel_r ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_nxt = tmsLevel_r ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_nxt = tmsLevel_r ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_nxt = tmsLevel_r ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_nxt = tmsLevel_r ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_nxt = tmsLevel_r ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_nxt = tmsLevel_r ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: state_nxt = tmsLevel_r ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_nxt = tmsLevel_r ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_nxt = tmsLevel_r ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_nxt = tmsLevel_r ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_nxt = tmsLevel_r ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_nxt = tmsLevel_r ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_nxt = tmsLevel_r ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: state_nxt = tmsLevel_r ? TAP_SEL_DR : TAP_IDLE;
      default: state_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= TAP_RESET;
    end
    else if (tckRise)
    begin
      state_r <= state_nxt;
    end
  end

  assign tapState = state_r;

  a_tap_steps_on_tck : assert property (@(posedge clk) disable iff (!rst_n)
    !tckRise |=> $stable(state_r))
    else $error("port state moved without a test clock rise");
  a_tap_idle_entry : assert property (@(posedge clk) disable iff (!rst_n)
    tckRise && state_r == TAP_RESET && !tmsLevel_r |=> state_r == TAP_IDLE)
    else $error("port did not leave reset on low select");

endmodule : pbs_tap_ctrl
`default_nettype wire

// [verif/pbs_ctl_model.sv]
// controller-side model that drives the burst sram pins
`timescale 1ns/1ps
`default_nettype none
module pbs_ctl_model
  import pbs_pkg::*;
(
  input wire logic clk, // system clock
  output var logic clockQualifyN, // high stalls
  output var logic [20:0] address, // word address
  output var logic bankSelect1N, // select, low
  output var logic bankSelect2, // select, high
  output var logic bankSelect3N, // select, low
  output var logic advanceOrLoad, // high advances
  output var logic writeStrobeN, // low writes
  output var logic [3:0] byteLaneSelectN, // lane writes, low
  output var logic outputDriveN, // drive enable, low
  output var logic [31:0] dataIn, // write data
  output var logic [3:0] parityIn // write parity
);
  logic [36:0] wPipe [2];
  logic burstWr;

  initial
  begin
    clockQualifyN = 1'b0;
    {bankSelect1N, bankSelect2, bankSelect3N} = 3'h5;
    {advanceOrLoad, writeStrobeN, outputDriveN} = 3'h2;
    address = '0;
    byteLaneSelectN = 4'hf;
    {parityIn, dataIn} = '0;
    wPipe = '{default: '0};
    burstWr = 1'b0;
  end

  // kind: 0 deselect, 1 load, 2 advance, 3 stall
  task automatic op(input int kind, input logic [20:0] a,
    input logic wrN, input logic [3:0] ln, input logic [35:0] d);
    logic [36:0] cur;
    @(posedge clk);
    #1;
    clockQualifyN = (kind == 3);
    // a stalled edge moves nothing, so the data pipe holds too
    if (kind == 3)
      return;
    address = a;
    advanceOrLoad = (kind == 2);
    writeStrobeN = wrN;
    byteLaneSelectN = ln;
    // selects are ignored on advance, so they wander there
    {bankSelect1N, bankSelect2, bankSelect3N} = (kind == 2) ? a[2:0] :
      (kind == 1) ? 3'h2 : 3'h5;
    if (kind != 2)
      burstWr = (kind == 1) && !wrN;
    cur = wPipe[1];
    wPipe[1] = wPipe[0];
    wPipe[0] = {(kind != 0) && burstWr, d};
    outputDriveN = cur[36];
    // released bus shows a changing pattern, never the last word
    {parityIn, dataIn} = cur[36] ? cur[35:0] : ~{parityIn, dataIn};
  endtask : op
endmodule : pbs_ctl_model
`default_nettype wire

// [verif/pbs_sram_core_tb.sv]
// self-checking bench of the pipelined burst sram core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module pbs_sram_core_tb
  import pbs_pkg::*;
  ;
  logic clk, rst_n, burstOrder, sleepRequest, tck, tms, sleeping;
  logic clockQualifyN, bankSelect1N, bankSelect2, bankSelect3N;
  logic advanceOrLoad, writeStrobeN, outputDriveN, dataOe, parityOe;
  logic [20:0] address;
  logic [3:0] byteLaneSelectN, parityIn, parityOut;
  logic [31:0] dataIn, dataOut;
  pbs_tap_state_t tapState;
  logic [35:0] mem [int];
  logic [35:0] expQ [$];
  logic [35:0] e;
  logic [36:0] lastSeen;
  logic qualPrev = 1'b1;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 24608;

  pbs_sram_core #(.ADDR_W(21), .LANES(4)) DUT (.clk(clk), .rst_n(rst_n),
    .clockQualifyN(clockQualifyN), .address(address),
    .bankSelect1N(bankSelect1N), .bankSelect2(bankSelect2),
    .bankSelect3N(bankSelect3N), .advanceOrLoad(advanceOrLoad),
    .writeStrobeN(writeStrobeN), .byteLaneSelectN(byteLaneSelectN),
    .outputDriveN(outputDriveN), .burstOrder(burstOrder),
    .sleepRequest(sleepRequest), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .parityIn(parityIn), .parityOut(parityOut),
    .parityOe(parityOe), .tck(tck), .tms(tms), .tapState(tapState),
    .sleeping(sleeping));

  pbs_ctl_model u_ctl (.clk(clk), .clockQualifyN(clockQualifyN),
    .address(address), .bankSelect1N(bankSelect1N),
    .bankSelect2(bankSelect2), .bankSelect3N(bankSelect3N),
    .advanceOrLoad(advanceOrLoad), .writeStrobeN(writeStrobeN),
    .byteLaneSelectN(byteLaneSelectN), .outputDriveN(outputDriveN),
    .dataIn(dataIn), .parityIn(parityIn));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [20:0] baddr(input logic [20:0] a, input int n);
    logic [1:0] k;
    k = n[1:0];
    return {a[20:2], burstOrder ? a[1:0] ^ k : a[1:0] + k};
  endfunction : baddr

  task automatic idle(input int n);
    repeat (n) u_ctl.op(0, '0, 1'b1, 4'hf, '0);
  endtask : idle

  // st: beat before which two stalled edges go in
  task automatic burst(input logic wr, input logic [20:0] a, input int n,
    input int st, input logic full);
    logic [20:0] ba;
    logic [3:0] ln;
    logic [35:0] d;
    for (int i = 0; i < n; i++)
    begin
      if (i == st)
        repeat (2) u_ctl.op(3, a, 1'b1, 4'hf, '0);
      ba = baddr(a, i);
      ln = full ? 4'h0 : 4'($random(seed));
      d = {4'($random(seed)), 32'($random(seed))};
      for (int l = 0; l < 4; l++)
      begin
        if (wr && !ln[l])
        begin
          mem[ba][8*l +: 8] = d[8*l +: 8];
          mem[ba][32+l] = d[32+l];
        end
      end
      if (!wr)
        expQ.push_back(mem[ba]);
      u_ctl.op(i == 0 ? 1 : 2, i == 0 ? a : 21'($random(seed)),
        i == 0 ? !wr : 1'($random(seed)), ln, d);
    end
  endtask : burst

  task automatic tapStep(input logic m, input pbs_tap_state_t ex);
    tms = m;
    idle(5);
    tck = 1'b1;
    idle(5);
    tck = 1'b0;
    idle(5);
    `CHK("tap state", ex, tapState)
  endtask : tapStep

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst_n && qualPrev && dataOe === 1'b1)
    begin
      if (expQ.size() == 0)
        `CHK("unexpected drive", 1'b0, dataOe)
      else
      begin
        e = expQ.pop_front();
        `CHK("read data", e, {parityOut, dataOut})
      end
    end
    if (rst_n && !qualPrev && sleeping === 1'b0)
      `CHK("held output", lastSeen, {dataOe, parityOut, dataOut})
    lastSeen = {dataOe, parityOut, dataOut};
    qualPrev = !rst_n || (clockQualifyN === 1'b0 && sleeping === 1'b0);
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    {rst_n, burstOrder, sleepRequest, tck, tms} = 5'h09;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK("drive after reset", 1'b0, dataOe)
    `CHK("tap after reset", TAP_RESET, tapState)
    burstOrder = 1'b0;
    idle(5);
    burst(1'b1, 21'h100, 4, 9, 1'b1);
    idle(2);
    burst(1'b0, 21'h102, 4, 2, 1'b1); // linear wrap, stalled
    burstOrder = 1'b1;
    idle(5);
    burst(1'b0, 21'h101, 4, 9, 1'b1); // interleaved
    burst(1'b1, 21'h101, 4, 1, 1'b0); // random lanes, stalled
    idle(2);
    burst(1'b0, 21'h100, 4, 9, 1'b1);
    idle(1);
    u_ctl.op(2, '0, 1'b1, 4'hf, '0); // advance keeps deselect
    // back-to-back single operations in random order
    repeat (30)
    begin
      case ($unsigned($random(seed)) % 3)
        0: burst(1'b1, 21'h300 + 21'($random(seed) & 7), 1, 9, 1'b1);
        1: burst(1'b0, 21'h100 + 21'($random(seed) & 3), 1, 9, 1'b1);
        default: idle(1);
      endcase
    end
    idle(2);
    for (int k = 0; k < 8; k++)
    begin
      if (mem.exists(21'h300 + k))
        burst(1'b0, 21'h300 + 21'(k), 1, 9, 1'b1);
    end
    idle(2);
    sleepRequest = 1'b1;
    idle(6);
    `CHK("sleep entered", 1'b1, sleeping)
    sleepRequest = 1'b0;
    idle(6);
    `CHK("sleep left", 1'b0, sleeping)
    burst(1'b0, 21'h100, 4, 9, 1'b1);
    tapStep(1'b0, TAP_IDLE);
    tapStep(1'b1, TAP_SEL_DR);
    tapStep(1'b1, TAP_SEL_IR);
    tapStep(1'b1, TAP_RESET);
    idle(3);
    `CHK("reads left", 0, expQ.size())
    stop_test();
  end
endmodule : pbs_sram_core_tb
`default_nettype wire
